// file: rtl/hsw_pkg.sv
package hsw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Packet type indicators that lead each transport packet
    localparam logic [7:0] HSW_PKT_CMD = 8'h01;
    localparam logic [7:0] HSW_PKT_ACL = 8'h02;
    localparam logic [7:0] HSW_PKT_SYNC = 8'h03;
    localparam logic [7:0] HSW_PKT_EVT = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // Line timing
    localparam int HSW_CLK_HZ = 25000000;
    localparam int HSW_BAUD_DEF = 115200;
    localparam int HSW_BIT_CYC_DEF = HSW_CLK_HZ / HSW_BAUD_DEF;
    localparam int HSW_DATA_BITS = 8;
    localparam logic [3:0] HSW_LAST_BIT = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] ptype;
        logic [7:0] data;
        logic       first;
        logic       last;
    } hsw_beat_t;

    typedef struct packed {
        logic rxd;
        logic cts_n;
        logic dev_wake;
        logic wlan_act;
    } hsw_pins_t;

endpackage

// file: rtl/hsw_sync3.sv
module hsw_sync3 (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic d_i,
    input wire logic rst_val_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Three stages; output changes once stages two and three agree
    // Reset level matches the pin's idle level, so no false edge follows reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_r <= rst_val_i;
            s2_r <= rst_val_i;
            s3_r <= rst_val_i;
            q_o <= rst_val_i;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_o <= s3_r;
            end
        end
    end
endmodule

// file: rtl/hsw_uart_wake.sv
// Function
// - Active-low reset pin from host holds the block in reset while low.
// - Link carries commands, events, async data and synchronous data packets.
// - H4 framing on four wires: TXD, RXD, RTS and CTS.
// - Transmit and receive run concurrently and independently.
// - Module raises its wake output whenever it has data for the host.
// - Each side sleeps independently; wake lines bring the other back.
// - Module wake output rises on new packet or radio event to process.
// - Host wake input raises an internal interrupt waking the module.
// - Module drives a radio activity request output for coexistence.
module hsw_uart_wake
    import hsw_pkg::*;
#(
    parameter int BIT_CYC = HSW_BIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reset_n_i,
    input wire logic rxd_i,
    input wire logic cts_n_i,
    input wire logic host_to_module_wakeup_i,
    input wire logic wlan_activity_in_i,
    input wire hsw_pkg::hsw_beat_t tx_beat_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic rx_room_i,
    input wire logic radio_event_i,
    input wire logic radio_busy_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic txd_o,
    output logic rts_n_o,
    output logic module_to_host_wakeup_o,
    output logic radio_activity_request_o,
    output logic wake_irq_o,
    output logic wlan_busy_o
);
    import hsw_pkg::*;

    localparam int CW = $clog2(BIT_CYC + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
    localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYC / 2);

    typedef enum logic [1:0] {
        HSW_IDLE = 2'b00,
        HSW_START = 2'b01,
        HSW_DATA = 2'b10,
        HSW_STOP = 2'b11
    } hsw_st_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rst_pin_s;
    logic rxd_s;
    logic cts_n_s;
    logic dev_wake_s;
    logic wlan_s;
    logic rst_all;

    hsw_sync3 u_sy_rst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(reset_n_i), .rst_val_i(1'b1), .q_o(rst_pin_s));
    hsw_sync3 u_sy_rxd (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(rxd_i), .rst_val_i(1'b1), .q_o(rxd_s));
    hsw_sync3 u_sy_cts (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(cts_n_i), .rst_val_i(1'b1), .q_o(cts_n_s));
    hsw_sync3 u_sy_wak (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .d_i(host_to_module_wakeup_i), .rst_val_i(1'b0), .q_o(dev_wake_s));
    hsw_sync3 u_sy_wla (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .d_i(wlan_activity_in_i), .rst_val_i(1'b0), .q_o(wlan_s));

    // Pin reset low holds everything past the pin synchronisers in reset
    assign rst_all = sys_rst_i | ~rst_pin_s;

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: type byte first, then payload bytes
    hsw_st_t tx_st_r;
    logic [CW-1:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic [7:0] tx_pay_r;
    logic tx_pend_r;
    logic tx_inpkt_r;
    logic tx_last_r;

    // Serialiser, paced by CTS
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            tx_st_r <= HSW_IDLE;
            tx_cnt_r <= '0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 8'h00;
            tx_pay_r <= 8'h00;
            tx_pend_r <= 1'b0;
            tx_inpkt_r <= 1'b0;
            tx_last_r <= 1'b0;
            txd_o <= 1'b1;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= 1'b0;
            case (tx_st_r)
                HSW_IDLE: begin
                    txd_o <= 1'b1;
                    if (tx_pend_r && !cts_n_s) begin
                        tx_sh_r <= tx_pay_r;
                        tx_pend_r <= 1'b0;
                        tx_st_r <= HSW_START;
                        tx_cnt_r <= '0;
                        txd_o <= 1'b0;
                    end else if (tx_valid_i && !tx_ready_o && !cts_n_s) begin
                        tx_ready_o <= 1'b1;
                        tx_last_r <= tx_beat_i.last;
                        if (tx_beat_i.first || !tx_inpkt_r) begin
                            tx_sh_r <= tx_beat_i.ptype;
                            tx_pay_r <= tx_beat_i.data;
                            tx_pend_r <= 1'b1;
                        end else begin
                            tx_sh_r <= tx_beat_i.data;
                        end
                        tx_inpkt_r <= ~tx_beat_i.last;
                        tx_st_r <= HSW_START;
                        tx_cnt_r <= '0;
                        txd_o <= 1'b0;
                    end
                end
                HSW_START: begin
                    tx_cnt_r <= tx_cnt_r + 1'b1;
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_cnt_r <= '0;
                        tx_bit_r <= 4'h0;
                        txd_o <= tx_sh_r[0];
                        tx_st_r <= HSW_DATA;
                    end
                end
                HSW_DATA: begin
                    tx_cnt_r <= tx_cnt_r + 1'b1;
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_cnt_r <= '0;
                        if (tx_bit_r == HSW_LAST_BIT) begin
                            txd_o <= 1'b1;
                            tx_st_r <= HSW_STOP;
                        end else begin
                            tx_bit_r <= tx_bit_r + 4'h1;
                            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                            txd_o <= tx_sh_r[1];
                        end
                    end
                end
                HSW_STOP: begin
                    tx_cnt_r <= tx_cnt_r + 1'b1;
                    if (tx_cnt_r == BIT_LAST) begin
                        tx_cnt_r <= '0;
                        tx_st_r <= HSW_IDLE;
                    end
                end
                default: tx_st_r <= HSW_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver, independent of the transmitter
    hsw_st_t rx_st_r;
    logic [CW-1:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;

    // Deserialiser with mid-bit sampling
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            rx_st_r <= HSW_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            case (rx_st_r)
                HSW_IDLE: begin
                    rx_cnt_r <= '0;
                    if (!rxd_s) begin
                        rx_st_r <= HSW_START;
                    end
                end
                HSW_START: begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    if (rx_cnt_r == HALF_BIT) begin
                        rx_cnt_r <= '0;
                        rx_bit_r <= 4'h0;
                        rx_st_r <= rxd_s ? HSW_IDLE : HSW_DATA;
                    end
                end
                HSW_DATA: begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    if (rx_cnt_r == BIT_LAST) begin
                        rx_cnt_r <= '0;
                        rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == HSW_LAST_BIT) begin
                            rx_st_r <= HSW_STOP;
                        end
                    end
                end
                HSW_STOP: begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    if (rx_cnt_r == BIT_LAST) begin
                        rx_st_r <= HSW_IDLE;
                        if (rxd_s) begin
                            rx_data_o <= rx_sh_r;
                            rx_valid_o <= 1'b1;
                        end
                    end
                end
                default: rx_st_r <= HSW_IDLE;
            endcase
        end
    end

    // Request-to-send low while there is room
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            rts_n_o <= 1'b1;
        end else begin
            rts_n_o <= ~rx_room_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake handshake
    logic evt_pend_r;
    logic dev_wake_d_r;

    // Pending flag: event set wins over clear on packet end
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            evt_pend_r <= 1'b0;
        end else if (radio_event_i) begin
            evt_pend_r <= 1'b1;
        end else if (tx_ready_o && tx_last_r) begin
            evt_pend_r <= 1'b0;
        end
    end

    // Wake out held while data waits or a packet is open
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            module_to_host_wakeup_o <= 1'b0;
        end else begin
            module_to_host_wakeup_o <= evt_pend_r | radio_event_i | tx_valid_i
                | tx_inpkt_r | tx_pend_r | (tx_st_r != HSW_IDLE);
        end
    end

    // Host wake rising edge pulses the internal interrupt
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            dev_wake_d_r <= 1'b0;
            wake_irq_o <= 1'b0;
        end else begin
            dev_wake_d_r <= dev_wake_s;
            wake_irq_o <= dev_wake_s & ~dev_wake_d_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coexistence
    always_ff @(posedge clk_i) begin
        if (rst_all) begin
            radio_activity_request_o <= 1'b0;
            wlan_busy_o <= 1'b0;
        end else begin
            radio_activity_request_o <= radio_busy_i;
            wlan_busy_o <= wlan_s;
        end
    end
endmodule

// file: tb/hsw_uart_wake_assertions.sv
module hsw_uart_wake_chk
    import hsw_pkg::*;
#(
    parameter int BIT_CYC = HSW_BIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reset_n_i,
    input wire logic cts_n_i,
    input wire logic host_to_module_wakeup_i,
    input wire logic wlan_activity_in_i,
    input wire logic rx_room_i,
    input wire logic radio_event_i,
    input wire logic radio_busy_i,
    input wire logic tx_ready_o,
    input wire logic txd_o,
    input wire logic rts_n_o,
    input wire logic module_to_host_wakeup_o,
    input wire logic radio_activity_request_o,
    input wire logic wake_irq_o,
    input wire logic wlan_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    // Both resets silence every check
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !reset_n_i);
    ////////////////////////////////////////////////////////////////////////
    // Port relations
    room_rts_a: assert property (rx_room_i |=> !rts_n_o)
        else $error("rts high while room");
    full_rts_a: assert property (!rx_room_i |=> rts_n_o)
        else $error("rts low without room");
    act_on_a: assert property (radio_busy_i |=> radio_activity_request_o)
        else $error("activity request missing");
    act_off_a: assert property (!radio_busy_i |=> !radio_activity_request_o)
        else $error("activity request stuck");
    cts_hold_a: assert property (cts_n_i [*8] |-> !tx_ready_o)
        else $error("beat taken while cts high");
    ready_pulse_a: assert property (tx_ready_o |=> !tx_ready_o)
        else $error("ready longer than one cycle");
    start_bit_a: assert property (tx_ready_o |-> !txd_o ##1 !txd_o)
        else $error("no start bit after accept");
    irq_rise_a: assert property ($rose(host_to_module_wakeup_i) |-> ##[1:6] wake_irq_o)
        else $error("host wake gave no interrupt");
    irq_quiet_a: assert property (!host_to_module_wakeup_i [*8] |-> !wake_irq_o)
        else $error("interrupt without host wake");
    irq_pulse_a: assert property (wake_irq_o |=> !wake_irq_o)
        else $error("interrupt longer than one cycle");
    event_wake_a: assert property (radio_event_i |-> ##[1:2] module_to_host_wakeup_o)
        else $error("event did not wake host");
    wake_hold_a: assert property ($fell(module_to_host_wakeup_o) |-> txd_o && $past(txd_o, 4))
        else $error("host wake dropped early");
    wlan_sync_a: assert property (wlan_activity_in_i [*6] |-> wlan_busy_o)
        else $error("wlan activity not seen");
    wlan_idle_a: assert property (!wlan_activity_in_i [*6] |-> !wlan_busy_o)
        else $error("wlan busy without activity");
endmodule

bind hsw_uart_wake hsw_uart_wake_chk #(.BIT_CYC(BIT_CYC)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reset_n_i(reset_n_i), .cts_n_i(cts_n_i),
    .host_to_module_wakeup_i(host_to_module_wakeup_i), .wlan_activity_in_i(wlan_activity_in_i),
    .rx_room_i(rx_room_i), .radio_event_i(radio_event_i), .radio_busy_i(radio_busy_i),
    .tx_ready_o(tx_ready_o), .txd_o(txd_o), .rts_n_o(rts_n_o),
    .module_to_host_wakeup_o(module_to_host_wakeup_o),
    .radio_activity_request_o(radio_activity_request_o), .wake_irq_o(wake_irq_o),
    .wlan_busy_o(wlan_busy_o)
);

// file: tb/hsw_host_model.sv
module hsw_host_model #(
    parameter int BIT_CYC = 8
) (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic rts_n_i,
    output logic rxd_o,
    output logic cts_n_o,
    output logic host_wake_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got_q[$];
    logic stall;
    // Stall lifts clear-to-send
    assign cts_n_o = stall;
    initial begin
        rxd_o = 1'b1;
        stall = 1'b0;
        host_wake_o = 1'b0;
    end
    // Receiver for module bytes, 8N1 lsb first
    always begin : rx_proc
        logic [7:0] b;
        @(negedge txd_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        if (txd_i) got_q.push_back(b);
    end
    // Type byte then two data bytes, wake held throughout
    task automatic send_pkt(input logic [7:0] t, input logic [7:0] a, input logic [7:0] b);
        logic [7:0] f [3];
        f = '{t, a, b};
        host_wake_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        foreach (f[i]) begin
            while (rts_n_i) @(posedge clk_i);
            for (int k = 0; k < 10; k++) begin
                rxd_o <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : f[i][k - 1];
                repeat (BIT_CYC) @(posedge clk_i);
            end
        end
        host_wake_o <= 1'b0;
    endtask
endmodule

// file: tb/hci_uart_sleep_wake_bench.sv
module hci_uart_sleep_wake_bench import hsw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BC = 8;
    logic clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1, wlan = 1'b0, tx_valid = 1'b0;
    logic room = 1'b0, ev = 1'b0, busy = 1'b0, live = 1'b0, room_d, busy_d;
    logic rxd, cts_n, hwake, txd, rts_n, mwake, act, irq, wbusy, tx_ready, rx_valid;
    logic [7:0] rx_data;
    logic [5:0] wlan_h = 6'h00;
    logic [7:0] exp_q[$], rx_q[$];
    logic [7:0] pts [4] = '{HSW_PKT_CMD, HSW_PKT_ACL, HSW_PKT_SYNC, HSW_PKT_EVT};
    hsw_beat_t beat = '0;
    int seed = 9, fails = 0, n_compared = 0, irqs = 0;

    always #20 clk = ~clk;
    hsw_uart_wake #(.BIT_CYC(BC)) u_dut (
        .clk_i(clk), .sys_rst_i(sys_rst), .reset_n_i(reset_n), .rxd_i(rxd), .cts_n_i(cts_n),
        .host_to_module_wakeup_i(hwake), .wlan_activity_in_i(wlan), .tx_beat_i(beat),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_room_i(room), .radio_event_i(ev),
        .radio_busy_i(busy), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .txd_o(txd),
        .rts_n_o(rts_n), .module_to_host_wakeup_o(mwake), .radio_activity_request_o(act),
        .wake_irq_o(irq), .wlan_busy_o(wbusy));
    hsw_host_model #(.BIT_CYC(BC)) u_host (.clk_i(clk), .txd_i(txd), .rts_n_i(rts_n),
        .rxd_o(rxd), .cts_n_o(cts_n), .host_wake_o(hwake));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One beat, held until accepted
    task automatic put_beat(input hsw_beat_t b);
        int n;
        n = 0;
        beat <= b;
        tx_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 4000);
        tx_valid <= 1'b0;
        if (n >= 4000) fails++;
        @(posedge clk);
    endtask
    // Random packet out, host sees type byte then data
    task automatic send_pkt(input logic [7:0] t, input int n);
        logic [7:0] d;
        exp_q = {t};
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            exp_q.push_back(d);
            put_beat('{ptype: t, data: d, first: (i == 0), last: (i == n - 1)});
        end
        // Room for a type byte and a payload byte still on the line
        repeat (24 * BC) @(posedge clk);
        chk(16'(u_host.got_q.size()), 16'(n + 1));
        foreach (exp_q[i]) chk(16'(u_host.got_q[i]), 16'(exp_q[i]));
        chk(16'(mwake), 16'h0000);
        u_host.got_q = {};
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Random side inputs, per-cycle checks, receive capture
    always @(posedge clk) begin
        room_d <= room;
        busy_d <= busy;
        wlan_h <= {wlan_h[4:0], wlan};
        if (live) begin
            if (($random(seed) & 15) == 0) room <= !room;
            if (($random(seed) & 15) == 0) busy <= !busy;
            if (($random(seed) & 15) == 0) wlan <= !wlan;
            chk(16'(rts_n), 16'(!room_d));
            chk(16'(act), 16'(busy_d));
            if (wlan_h == 6'h3F || wlan_h == 6'h00) chk(16'(wbusy), 16'(wlan_h[0]));
        end
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (irq === 1'b1) irqs++;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        live <= 1'b1;
        fork
            for (int p = 0; p < 4; p++) begin
                u_host.stall <= (p == 1);
                ev <= 1'b1;
                @(posedge clk);
                ev <= 1'b0;
                repeat (4) @(posedge clk);
                chk(16'(mwake), 16'h0001);
                fork
                    begin
                        repeat (40) @(posedge clk);
                        chk(16'(u_host.got_q.size()), 16'h0000);
                        u_host.stall <= 1'b0;
                    end
                join_none
                send_pkt(pts[p], p + 1);
            end
            begin : rx_part
                logic [7:0] a, b;
                for (int p = 0; p < 4; p++) begin
                    rx_q = {};
                    a = 8'($random(seed));
                    b = 8'($random(seed));
                    u_host.send_pkt(pts[p], a, b);
                    repeat (2 * BC) @(posedge clk);
                    chk(16'(rx_q.size()), 16'h0003);
                    chk(16'(rx_q[0]), 16'(pts[p]));
                    chk({rx_q[1], rx_q[2]}, {a, b});
                end
                chk(16'(irqs), 16'h0004);
            end
        join
        $display("test duplex traffic done");
        live <= 1'b0;
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        reset_n <= 1'b0;
        room <= 1'b0;
        busy <= 1'b0;
        wlan <= 1'b0;
        repeat (6) @(posedge clk);
        chk(16'({txd, rts_n, mwake, act}), 16'h000C);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        live <= 1'b1;
        send_pkt(HSW_PKT_CMD, 1);
        $display("test pin reset done");
        final_report;
    end
endmodule
